// [core/uieg_event_gate.sv]
// Interrupt endpoint event gate with register port and packet request.
`timescale 1ns/10ps
module uieg_event_gate (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    input wire uieg_pkg::uieg_events_s events_i,
    input wire logic [15:0] usb_change_i,
    input wire logic poll_i,
    output uieg_pkg::uieg_packet_s packet_o,
    output logic irq_o
);
    logic [31:0] enables_reg;
    logic [31:0] enables_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    uieg_pkg::uieg_packet_s packet_reg;
    uieg_pkg::uieg_packet_s packet_next;
    logic irq_reg;
    logic irq_next;
    logic usb_summary;
    logic [31:0] raw;
    logic hit;
    logic send;

    function automatic logic [31:0] pack_raw(input uieg_pkg::uieg_events_s e,
                                             input logic usb);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[uieg_pkg::OTP_DONE_BIT] = e.otp_write_done;
        r[uieg_pkg::TX_LP_ENTRY_BIT] = e.tx_lowpower_entry;
        r[uieg_pkg::TX_LP_EXIT_BIT] = e.tx_lowpower_exit;
        r[uieg_pkg::RX_LP_BIT] = e.rx_lowpower;
        r[uieg_pkg::MAC_RTO_BIT] = e.mac_reset_timeout;
        r[uieg_pkg::RX_OVF_BIT] = e.rx_fifo_overflow;
        r[uieg_pkg::TX_ERR_BIT] = e.tx_error;
        r[uieg_pkg::USB_STS_BIT] = usb;
        r[uieg_pkg::TX_DIS_BIT] = e.tx_disabled;
        r[uieg_pkg::RX_DIS_BIT] = e.rx_disabled;
        r[uieg_pkg::PHY_BIT] = e.phy_event;
        r[uieg_pkg::DATA_PORT_BIT] = e.data_port;
        r[uieg_pkg::MAC_ERR_BIT] = e.mac_error;
        r[uieg_pkg::TX_UNDR_BIT] = e.tx_fifo_underrun;
        r[uieg_pkg::TX_OVR_BIT] = e.tx_fifo_overrun;
        r[uieg_pkg::FRAME_PEND_BIT] = e.bulkin_frame_pending;
        r[uieg_pkg::PIN_LSB +: uieg_pkg::PIN_COUNT] = e.pin_event;
        return r;
    endfunction : pack_raw

    function automatic logic enabled_hit(input logic [31:0] r, input logic [31:0] en);
        return |(r & en & uieg_pkg::ENABLES_WMASK);
    endfunction : enabled_hit

    // Gating and packet decision.
    always_comb begin
        usb_summary = |usb_change_i;
        raw = pack_raw(events_i, usb_summary);
        hit = enabled_hit(raw, enables_reg);
        send = poll_i && (enables_reg[uieg_pkg::ALWAYS_BIT] || hit);
        packet_next.valid = send;
        packet_next.status = send ? raw : packet_reg.status;
        count_next = send ? count_reg + 16'h0001 : count_reg;
    end

    // Register writes, reads and interrupt status.
    always_comb begin
        enables_next = enables_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        rdata_next = 32'h0000_0000;
        if (reg_write_i) begin
            case (reg_addr_i)
                uieg_pkg::ENABLES_OFFSET: begin
                    enables_next = reg_wdata_i & uieg_pkg::ENABLES_WMASK;
                end
                uieg_pkg::IRQ_STATUS_OFFSET: begin
                    status_next = status_reg & ~reg_wdata_i[1:0];
                end
                uieg_pkg::IRQ_MASK_OFFSET: begin
                    mask_next = reg_wdata_i[1:0];
                end
                default: begin
                end
            endcase
        end
        if (send) begin
            status_next = status_next | uieg_pkg::IRQ_PACKET_SENT;
        end
        if (poll_i && !send) begin
            status_next = status_next | uieg_pkg::IRQ_POLL_EMPTY;
        end
        if (reg_read_i) begin
            case (reg_addr_i)
                uieg_pkg::ENABLES_OFFSET: rdata_next = enables_reg;
                uieg_pkg::IRQ_STATUS_OFFSET: rdata_next = {30'h0000_0000, status_reg};
                uieg_pkg::IRQ_MASK_OFFSET: rdata_next = {30'h0000_0000, mask_reg};
                uieg_pkg::PACKET_COUNT_OFFSET: rdata_next = {16'h0000, count_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        irq_next = |(status_next & mask_next);
    end

    // Packet group registers.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= 16'h0000;
            packet_reg <= '0;
        end else begin
            count_reg <= count_next;
            packet_reg <= packet_next;
        end
    end

    // Register group registers.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enables_reg <= uieg_pkg::ENABLES_RESET;
            rdata_reg <= 32'h0000_0000;
            status_reg <= 2'h0;
            mask_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            enables_reg <= enables_next;
            rdata_reg <= rdata_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign packet_o = packet_reg;
    assign irq_o = irq_reg;

    // Sequences for the poll and packet steps.
    sequence s_poll_taken;
        poll_i;
    endsequence : s_poll_taken

    sequence s_gated_poll;
        poll_i && !enables_reg[uieg_pkg::ALWAYS_BIT];
    endsequence : s_gated_poll

    sequence s_packet_out;
        packet_o.valid;
    endsequence : s_packet_out

    sequence s_no_packet;
        !packet_o.valid;
    endsequence : s_no_packet

    a_always_send: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && enables_reg[uieg_pkg::ALWAYS_BIT] |=> packet_o.valid)
        else $error("Always-send poll gave no packet.");
    a_gated_send: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && !enables_reg[uieg_pkg::ALWAYS_BIT] && !(|(raw & enables_reg))
        |=> !packet_o.valid)
        else $error("Packet sent without an enabled event.");
    a_enable_hit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && |(raw & enables_reg & uieg_pkg::ENABLES_WMASK) |=> packet_o.valid)
        else $error("Enabled event gave no packet.");
    a_otp_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && events_i.otp_write_done && enables_reg[uieg_pkg::OTP_DONE_BIT]
        |=> packet_o.valid)
        else $error("Write-done event not gated.");
    a_usb_summary: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && (usb_change_i != 16'h0000) ##1 packet_o.valid
        |-> packet_o.status[uieg_pkg::USB_STS_BIT])
        else $error("USB summary not reported.");
    a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_read_i && reg_addr_i == uieg_pkg::ENABLES_OFFSET
        |=> (reg_rdata_o & ~uieg_pkg::ENABLES_WMASK) == 32'h0000_0000)
        else $error("Reserved bits read nonzero.");
    a_raw_status: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        send |=> packet_o.status == $past(raw))
        else $error("Packet status is not raw status.");
    a_pin_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && |(events_i.pin_event & enables_reg[uieg_pkg::PIN_LSB +: uieg_pkg::PIN_COUNT])
        |=> packet_o.valid)
        else $error("Pin event not gated.");
    a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(status_reg[0]) && mask_reg[0] |-> irq_o)
        else $error("Interrupt not raised.");

    // Each event reaches a packet through its own enable bit.
    a_lp_entry_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.tx_lowpower_entry
            && enables_reg[uieg_pkg::TX_LP_ENTRY_BIT]) |=> s_packet_out)
        else $error("Low-power entry event not gated.");

    a_lp_exit_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.tx_lowpower_exit
            && enables_reg[uieg_pkg::TX_LP_EXIT_BIT]) |=> s_packet_out)
        else $error("Low-power exit event not gated.");

    a_rx_lp_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.rx_lowpower
            && enables_reg[uieg_pkg::RX_LP_BIT]) |=> s_packet_out)
        else $error("Receive low-power event not gated.");

    a_mac_timeout_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.mac_reset_timeout
            && enables_reg[uieg_pkg::MAC_RTO_BIT]) |=> s_packet_out)
        else $error("Reset timeout event not gated.");

    a_overflow_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.rx_fifo_overflow
            && enables_reg[uieg_pkg::RX_OVF_BIT]) |=> s_packet_out)
        else $error("Overflow event not gated.");

    a_tx_error_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.tx_error
            && enables_reg[uieg_pkg::TX_ERR_BIT]) |=> s_packet_out)
        else $error("Transmit error event not gated.");

    a_usb_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (usb_summary
            && enables_reg[uieg_pkg::USB_STS_BIT]) |=> s_packet_out)
        else $error("USB summary event not gated.");

    a_tx_disabled_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.tx_disabled
            && enables_reg[uieg_pkg::TX_DIS_BIT]) |=> s_packet_out)
        else $error("Transmit disabled event not gated.");

    a_rx_disabled_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.rx_disabled
            && enables_reg[uieg_pkg::RX_DIS_BIT]) |=> s_packet_out)
        else $error("Receive disabled event not gated.");

    a_phy_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.phy_event
            && enables_reg[uieg_pkg::PHY_BIT]) |=> s_packet_out)
        else $error("PHY event not gated.");

    a_data_port_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.data_port
            && enables_reg[uieg_pkg::DATA_PORT_BIT]) |=> s_packet_out)
        else $error("Data port event not gated.");

    a_mac_error_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.mac_error
            && enables_reg[uieg_pkg::MAC_ERR_BIT]) |=> s_packet_out)
        else $error("MAC error event not gated.");

    a_underrun_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.tx_fifo_underrun
            && enables_reg[uieg_pkg::TX_UNDR_BIT]) |=> s_packet_out)
        else $error("Underrun event not gated.");

    a_overrun_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.tx_fifo_overrun
            && enables_reg[uieg_pkg::TX_OVR_BIT]) |=> s_packet_out)
        else $error("Overrun event not gated.");

    a_pending_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 (events_i.bulkin_frame_pending
            && enables_reg[uieg_pkg::FRAME_PEND_BIT]) |=> s_packet_out)
        else $error("Frame pending event not gated.");

    a_always_packet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 enables_reg[uieg_pkg::ALWAYS_BIT]
        |=> s_packet_out)
        else $error("Always-send poll was dropped.");

    a_packet_on_hit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_poll_taken ##0 enabled_hit(raw, enables_reg)
        |=> s_packet_out)
        else $error("Enabled hit gave no packet.");

    a_blocked_poll: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_gated_poll ##0 !enabled_hit(raw, enables_reg)
        |=> s_no_packet)
        else $error("Disabled event gave a packet.");

    a_valid_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !poll_i
        |=> s_no_packet)
        else $error("Packet sent without a poll.");

    a_status_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !send
        |=> $stable(packet_o.status))
        else $error("Packet status moved without a packet.");

    a_reserved_status: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        send
        |=> (packet_o.status & ~uieg_pkg::ENABLES_WMASK) == 32'h0000_0000)
        else $error("Packet status has reserved bits set.");

    a_usb_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && (usb_change_i == 16'h0000) ##1 packet_o.valid
        |-> !packet_o.status[uieg_pkg::USB_STS_BIT])
        else $error("USB summary set without a change.");

    a_enables_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_write_i && reg_addr_i == uieg_pkg::ENABLES_OFFSET
        |=> enables_reg == ($past(reg_wdata_i) & uieg_pkg::ENABLES_WMASK))
        else $error("Enable write did not land.");

    a_read_enables: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_read_i && reg_addr_i == uieg_pkg::ENABLES_OFFSET
        |=> reg_rdata_o == $past(enables_reg))
        else $error("Enable read gave wrong data.");

    a_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        send
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("Packet count did not step.");

    a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !reg_read_i
        |=> reg_rdata_o == 32'h0000_0000)
        else $error("Read data not zero when idle.");

    a_mask_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_write_i && reg_addr_i == uieg_pkg::IRQ_MASK_OFFSET
        |=> mask_reg == $past(reg_wdata_i[1:0]))
        else $error("Mask write did not land.");

    a_status_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_write_i && reg_addr_i == uieg_pkg::IRQ_STATUS_OFFSET && !poll_i
        |=> (status_reg & $past(reg_wdata_i[1:0])) == 2'h0)
        else $error("Status bits not cleared.");

    a_sent_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        send
        |=> status_reg[0])
        else $error("Packet sent flag not set.");

    a_empty_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        poll_i && !send
        |=> status_reg[1])
        else $error("Empty poll flag not set.");

    a_irq_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !(|(status_reg & mask_reg))
        |-> !irq_o)
        else $error("Interrupt high with no unmasked status.");
endmodule : uieg_event_gate

// [core/uieg_pkg.sv]
// Package of constants and types for the interrupt endpoint event gate.
// Overview of operation
// - Always-send bit sends packet every poll.
// - Otherwise send only on enabled event.
// - Enable bit gates event; resets to zero.
// - Bit 28 gates memory write done.
// - Bits 26,25,24 gate low-power events.
// - Bit 23 gates MAC reset timeout.
// - Bit 22 overflow, bit 21 transmit error.
// - Bit 20 gates USB status summary.
// - Bits 19,18 gate transmit/receive disabled.
// - Bits 17,16 gate PHY and data port.
// - Bit 15 gates MAC error.
// - Bits 14,13 gate FIFO underrun, overrun.
// - Bit 12 gates bulk-in frame pending.
// - Bits 7:0 gate eight pin events.
// - Summary event is OR of change bits.
package uieg_pkg;
    localparam logic [7:0] ENABLES_OFFSET = 8'h98;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hA0;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'hA4;
    localparam logic [7:0] PACKET_COUNT_OFFSET = 8'hA8;
    localparam logic [31:0] ENABLES_RESET = 32'h0000_0000;
    localparam logic [31:0] ENABLES_WMASK = 32'h97FF_F0FF;
    localparam int ALWAYS_BIT = 31;
    localparam int OTP_DONE_BIT = 28;
    localparam int TX_LP_ENTRY_BIT = 26;
    localparam int TX_LP_EXIT_BIT = 25;
    localparam int RX_LP_BIT = 24;
    localparam int MAC_RTO_BIT = 23;
    localparam int RX_OVF_BIT = 22;
    localparam int TX_ERR_BIT = 21;
    localparam int USB_STS_BIT = 20;
    localparam int TX_DIS_BIT = 19;
    localparam int RX_DIS_BIT = 18;
    localparam int PHY_BIT = 17;
    localparam int DATA_PORT_BIT = 16;
    localparam int MAC_ERR_BIT = 15;
    localparam int TX_UNDR_BIT = 14;
    localparam int TX_OVR_BIT = 13;
    localparam int FRAME_PEND_BIT = 12;
    localparam int PIN_LSB = 0;
    localparam int PIN_COUNT = 8;
    localparam int USB_CHANGE_BITS = 16;
    localparam logic [1:0] IRQ_PACKET_SENT = 2'h1;
    localparam logic [1:0] IRQ_POLL_EMPTY = 2'h2;
    typedef struct packed {
        logic otp_write_done;
        logic tx_lowpower_entry;
        logic tx_lowpower_exit;
        logic rx_lowpower;
        logic mac_reset_timeout;
        logic rx_fifo_overflow;
        logic tx_error;
        logic tx_disabled;
        logic rx_disabled;
        logic phy_event;
        logic data_port;
        logic mac_error;
        logic tx_fifo_underrun;
        logic tx_fifo_overrun;
        logic bulkin_frame_pending;
        logic [7:0] pin_event;
    } uieg_events_s;
    typedef struct packed {
        logic valid;
        logic [31:0] status;
    } uieg_packet_s;
endpackage : uieg_pkg

// [testbench/uieg_host_model.sv]
// Host model that polls the interrupt endpoint and captures the packets.
`timescale 1ns/10ps
module uieg_host_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire uieg_pkg::uieg_packet_s packet_i,
    output logic poll_o,
    output logic got_o,
    output logic [31:0] status_o
);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            poll_o <= 1'b0;
            got_o <= 1'b0;
            status_o <= 32'h0000_0000;
        end else begin
            poll_o <= req_i;
            got_o <= packet_i.valid;
            if (packet_i.valid) begin
                status_o <= packet_i.status;
            end
        end
    end
endmodule : uieg_host_model

// [testbench/usb_interrupt_endpoint_event_gate_test.sv]
// Testbench for the interrupt endpoint event gate.
`timescale 1ns/10ps
module usb_interrupt_endpoint_event_gate_test;
    localparam logic [31:0] EV_MASK = 32'h17FF_F0FF;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic req = 1'b0;
    logic poll;
    logic got;
    logic irq;
    logic [31:0] rdata;
    logic [31:0] stat;
    logic [31:0] v;
    logic [15:0] usb_chg = 16'h0000;
    uieg_pkg::uieg_events_s ev = '0;
    uieg_pkg::uieg_packet_s pkt;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_pkt = 0;
    uieg_event_gate i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
        .events_i(ev), .usb_change_i(usb_chg), .poll_i(poll), .packet_o(pkt), .irq_o(irq));
    uieg_host_model i_host (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .req_i(req),
        .packet_i(pkt), .poll_o(poll), .got_o(got), .status_o(stat));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // Presents an event image laid out like the enable register, then polls once.
    task automatic do_poll(input logic [31:0] img, input logic sent);
        @(posedge ref_clk);
        ev <= {img[28], img[26:21], img[19:12], img[7:0]};
        usb_chg <= img[20] ? 16'h8000 : 16'h0000;
        req <= 1'b1;
        @(posedge ref_clk);
        req <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({31'h0, got}, {31'h0, sent});
        if (sent) begin
            chk(stat, img);
            n_pkt++;
        end
    endtask : do_poll
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_reg(uieg_pkg::ENABLES_OFFSET, v);
        chk(v, 32'h0000_0000);
        wr_reg(uieg_pkg::ENABLES_OFFSET, 32'hFFFF_FFFF);
        rd_reg(uieg_pkg::ENABLES_OFFSET, v);
        chk(v, 32'h97FF_F0FF);
        wr_reg(8'hFC, 32'hFFFF_FFFF);
        rd_reg(8'hFC, v);
        chk(v, 32'h0000_0000);
        $display("Test registers done");
        wr_reg(uieg_pkg::IRQ_MASK_OFFSET, 32'h0000_0001);
        for (int b = 0; b < 29; b++) begin
            if (EV_MASK[b]) begin
                wr_reg(uieg_pkg::ENABLES_OFFSET, 32'h1 << b);
                do_poll(EV_MASK & ~(32'h1 << b), 1'b0);
                do_poll(32'h1 << b, 1'b1);
            end
        end
        wr_reg(uieg_pkg::ENABLES_OFFSET, EV_MASK);
        do_poll(EV_MASK, 1'b1);
        wr_reg(uieg_pkg::ENABLES_OFFSET, 32'h8000_0000);
        do_poll(32'h0000_0000, 1'b1);
        $display("Test gating done");
        rd_reg(uieg_pkg::PACKET_COUNT_OFFSET, v);
        chk(v, 32'(n_pkt));
        chk({31'h0, irq}, 32'h1);
        rd_reg(uieg_pkg::IRQ_STATUS_OFFSET, v);
        chk(v, 32'h0000_0003);
        wr_reg(uieg_pkg::IRQ_STATUS_OFFSET, 32'h0000_0003);
        rd_reg(uieg_pkg::IRQ_STATUS_OFFSET, v);
        chk(v, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
        $display("Test interrupt done");
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_reg(uieg_pkg::ENABLES_OFFSET, v);
        chk(v, 32'h0000_0000);
        rd_reg(uieg_pkg::PACKET_COUNT_OFFSET, v);
        chk(v, 32'h0000_0000);
        $display("Test reset done");
        test_done();
    end
endmodule : usb_interrupt_endpoint_event_gate_test
